// File: dct_pin_model.sv
// Partner model: timer event pins and external oscillator
`timescale 1ns/1ps
`default_nettype none
module dct_pin_model (
    input wire logic clk,
    input wire logic [1:0] fire,
    output logic [1:0] ev_pin,
    output logic osc
);
    // ---------------------------------------------------------------
    // Event pulse: low two clocks, then high at least two
    // ---------------------------------------------------------------
    logic [1:0][2:0] cnt = '0;
    logic [1:0] div = 2'h0;
    always_ff @(posedge clk) begin
        div <= div + 2'h1;
        for (int i = 0; i < 2; i++) begin
            if (cnt[i] != 3'h0) begin
                cnt[i] <= cnt[i] - 3'h1;
            end else if (fire[i]) begin
                cnt[i] <= 3'h4;
            end
        end
    end
    assign ev_pin[0] = (cnt[0] < 3'h3);
    assign ev_pin[1] = (cnt[1] < 3'h3);
    assign osc = div[1];
endmodule : dct_pin_model
`default_nettype wire

// File: dct_pkg.sv
// Package: register map, field positions and constants of the dual counter/timer
package dct_pkg;
    // ---------------------------------------------------------------
    // Register addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_RUN_STATUS = 8'h88;
    localparam logic [7:0] ADDR_MODE_CONFIG = 8'h89;
    localparam logic [7:0] ADDR_A_LOW = 8'h8A;
    localparam logic [7:0] ADDR_B_LOW = 8'h8B;
    localparam logic [7:0] ADDR_A_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_B_HIGH = 8'h8D;
    localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8E;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int RS_B_OVF = 7;
    localparam int RS_B_RUN = 6;
    localparam int RS_A_OVF = 5;
    localparam int RS_A_RUN = 4;
    localparam int MC_B_GATE = 7;
    localparam int MC_B_CSEL = 6;
    localparam int MC_B_MODE = 4;
    localparam int MC_A_GATE = 3;
    localparam int MC_A_CSEL = 2;
    localparam int MC_A_MODE = 0;
    localparam int CC_T3_HIGH = 7;
    localparam int CC_T3_LOW = 6;
    localparam int CC_T2_HIGH = 5;
    localparam int CC_T2_LOW = 4;
    localparam int CC_B_CLK = 3;
    localparam int CC_A_CLK = 2;
    localparam int CC_PRESCALE = 0;
    // ---------------------------------------------------------------
    // Mode and prescale codes
    // ---------------------------------------------------------------
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    localparam logic [1:0] PRE_DIV12 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;
    localparam logic [1:0] PRE_DIV48 = 2'h2;
    localparam logic [1:0] PRE_EXT8 = 2'h3;
    localparam int DIV12 = 12;
    localparam int DIV4 = 4;
    localparam int DIV48 = 48;
    localparam int EXT_DIV = 8;
    localparam logic [5:0] TERM12 = 6'(DIV12 - 1);
    localparam logic [5:0] TERM4 = 6'(DIV4 - 1);
    localparam logic [5:0] TERM48 = 6'(DIV48 - 1);
    localparam logic [2:0] TERM_EXT = 3'(EXT_DIV - 1);
    // ---------------------------------------------------------------
    // Synchronised pin indices
    // ---------------------------------------------------------------
    localparam int PIN_IRQ_A = 0;
    localparam int PIN_IRQ_B = 1;
    localparam int PIN_EV_A = 2;
    localparam int PIN_EV_B = 3;
    localparam int PIN_OSC = 4;
    localparam int NPIN = 5;
    // ---------------------------------------------------------------
    // Register bus request
    // ---------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dct_sfr_req_t;
endpackage : dct_pkg

// File: dct_timer01.sv
// Module: two counter/timers with shared clock control and prescaler
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE_01] Prescale code divides system clock 12/4/48
// [RULE_02] Code 11 uses synchronised external oscillator/8
// [RULE_03] Timer B clock bit: system or prescaled
// [RULE_04] Timer A clock bit ignored when counting events, except by split high byte
// [RULE_05] Four timer 2/3 select bits stored
// [RULE_06] 13-bit: high byte plus low five bits
// [RULE_07] 13-bit wrap sets overflow flag
// [RULE_08] Counter select counts falling pin edges
// [RULE_09] Count needs run and gate condition
// [RULE_10] Run bit never clears the count
// [RULE_11] Timer B uses own bits, irq B gate
// [RULE_12] 16-bit mode counts all sixteen bits
// [RULE_13] 8-bit mode reloads low from high
// [RULE_14] Each timer configured independently
// [RULE_15] Split: A low byte uses A controls
// [RULE_16] Split: A high byte runs on B run
// [RULE_17] Split: timer B no events, no flag
// [RULE_18] Split: timer B runs unless mode 3
// [RULE_19] Timer B overflow pulse always exported
// [RULE_20] Mode field decode 13/16/reload/split
// [RULE_21] Flags cleared by software or vector ack
// [RULE_22] Event pins stable two clocks, rate/4
// [RULE_23] Pins synchronised, falling edge one pulse
// [RULE_24] Everything resets to zero
module dct_timer01 (
    input wire logic clk,
    input wire logic sys_rst,
    input wire dct_pkg::dct_sfr_req_t sfr_req,
    input wire logic timer_a_irq_ack,
    input wire logic timer_b_irq_ack,
    input wire logic ext_irq_a_input,
    input wire logic ext_irq_b_input,
    input wire logic ext_irq_a_polarity,
    input wire logic ext_irq_b_polarity,
    input wire logic timer_a_event_pin,
    input wire logic timer_b_event_pin,
    input wire logic ext_osc_clk,
    output logic [7:0] sfr_rdata,
    output logic timer_a_overflow,
    output logic timer_b_overflow,
    output logic timer_b_ovf_pulse,
    output logic tmr3_high_clk_sel,
    output logic tmr3_low_clk_sel,
    output logic tmr2_high_clk_sel,
    output logic tmr2_low_clk_sel
);
    // ---------------------------------------------------------------
    // Count step for one timer
    // ---------------------------------------------------------------
    localparam logic [1:0] MODE_13BIT_C = dct_pkg::MODE_13BIT;
    localparam logic [1:0] MODE_16BIT_C = dct_pkg::MODE_16BIT;
    localparam logic [1:0] MODE_RELOAD_C = dct_pkg::MODE_RELOAD;
    function automatic logic [16:0] dct_step(input logic [1:0] mode, input logic [7:0] hi,
                                             input logic [7:0] lo);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        s16 = {1'b0, hi, lo} + 17'h0_0001;
        s8 = {1'b0, lo} + 9'h001;
        case (mode) // RULE_20
            MODE_13BIT_C: dct_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]}; // RULE_06
            MODE_16BIT_C: dct_step = s16; // RULE_12
            MODE_RELOAD_C: dct_step = {s8[8], hi, (s8[8] ? hi : s8[7:0])}; // RULE_13
            default: dct_step = {s8[8], hi, s8[7:0]};
        endcase
    endfunction : dct_step

    logic [7:0] run_status_reg, mode_config_reg, clock_control_reg;
    logic [7:0] a_low_reg, a_high_reg, b_low_reg, b_high_reg, rdata_reg;
    logic b_pulse_reg;
    logic [dct_pkg::NPIN-1:0] pin_raw, sync1_reg, sync2_reg, prev_reg;
    logic [5:0] div_cnt_reg, div_term;
    logic [2:0] osc_cnt_reg;
    logic [1:0] prescale_code, mode_a, mode_b;
    logic pre_tick, osc_rise, split, base_a, base_b, ev_a_fall, ev_b_fall;
    logic gate_ok_a, gate_ok_b, run_a, run_b, inc_a, inc_b, inc_ah, ovf_a, ovf_b, ovf_ah;
    logic [16:0] step_a, step_b;
    logic wr_rs, wr_mc, wr_cc, wr_al, wr_ah, wr_bl, wr_bh;

    // ---------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ---------------------------------------------------------------
    assign pin_raw = {ext_osc_clk, timer_b_event_pin, timer_a_event_pin,
                      ext_irq_b_input, ext_irq_a_input};
    for (genvar i = 0; i < dct_pkg::NPIN; i++) begin : g_sync
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                sync1_reg[i] <= 1'b0;
                sync2_reg[i] <= 1'b0;
                prev_reg[i] <= 1'b0;
            end else begin
                sync1_reg[i] <= pin_raw[i]; // RULE_23
                sync2_reg[i] <= sync1_reg[i];
                prev_reg[i] <= sync2_reg[i];
            end
        end
    end
    assign ev_a_fall = prev_reg[dct_pkg::PIN_EV_A] & ~sync2_reg[dct_pkg::PIN_EV_A]; // RULE_23
    assign ev_b_fall = prev_reg[dct_pkg::PIN_EV_B] & ~sync2_reg[dct_pkg::PIN_EV_B]; // RULE_23
    assign osc_rise = sync2_reg[dct_pkg::PIN_OSC] & ~prev_reg[dct_pkg::PIN_OSC];

    // ---------------------------------------------------------------
    // Prescaler
    // ---------------------------------------------------------------
    assign prescale_code = clock_control_reg[dct_pkg::CC_PRESCALE +: 2];
    always_comb begin
        case (prescale_code) // RULE_01
            dct_pkg::PRE_DIV4: div_term = dct_pkg::TERM4;
            dct_pkg::PRE_DIV48: div_term = dct_pkg::TERM48;
            default: div_term = dct_pkg::TERM12;
        endcase
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_reg <= 6'h00; // RULE_24
        end else if (div_cnt_reg >= div_term) begin
            div_cnt_reg <= 6'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 6'h01;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_cnt_reg <= 3'h0; // RULE_24
        end else if (osc_rise) begin
            osc_cnt_reg <= osc_cnt_reg + 3'h1; // RULE_02
        end
    end
    assign pre_tick = (prescale_code == dct_pkg::PRE_EXT8) ?
                      (osc_rise && osc_cnt_reg == dct_pkg::TERM_EXT) : // RULE_02
                      (div_cnt_reg >= div_term); // RULE_01

    // ---------------------------------------------------------------
    // Count enables
    // ---------------------------------------------------------------
    assign mode_a = mode_config_reg[dct_pkg::MC_A_MODE +: 2]; // RULE_14
    assign mode_b = mode_config_reg[dct_pkg::MC_B_MODE +: 2]; // RULE_14
    assign split = (mode_a == dct_pkg::MODE_SPLIT);
    assign base_a = clock_control_reg[dct_pkg::CC_A_CLK] | pre_tick; // RULE_04
    assign base_b = clock_control_reg[dct_pkg::CC_B_CLK] | pre_tick; // RULE_03
    assign gate_ok_a = ~mode_config_reg[dct_pkg::MC_A_GATE] |
                       (sync2_reg[dct_pkg::PIN_IRQ_A] == ext_irq_a_polarity); // RULE_09
    assign gate_ok_b = ~mode_config_reg[dct_pkg::MC_B_GATE] |
                       (sync2_reg[dct_pkg::PIN_IRQ_B] == ext_irq_b_polarity); // RULE_11
    assign run_a = run_status_reg[dct_pkg::RS_A_RUN] & gate_ok_a; // RULE_09 RULE_15
    assign run_b = split ? (mode_b != dct_pkg::MODE_SPLIT) : // RULE_18
                   (run_status_reg[dct_pkg::RS_B_RUN] & gate_ok_b &
                    (mode_b != dct_pkg::MODE_SPLIT)); // RULE_20
    assign inc_a = run_a & (mode_config_reg[dct_pkg::MC_A_CSEL] ? ev_a_fall : base_a); // RULE_08
    assign inc_b = run_b & ((mode_config_reg[dct_pkg::MC_B_CSEL] && !split) ?
                            ev_b_fall : base_b); // RULE_17
    assign inc_ah = split & run_status_reg[dct_pkg::RS_B_RUN] & base_a; // RULE_16
    assign step_a = dct_step(mode_a, a_high_reg, a_low_reg);
    assign step_b = dct_step(mode_b, b_high_reg, b_low_reg);
    assign ovf_a = inc_a & step_a[16]; // RULE_07 RULE_15
    assign ovf_b = inc_b & step_b[16];
    assign ovf_ah = inc_ah & (a_high_reg == dct_pkg::BYTE_ONES);

    // ---------------------------------------------------------------
    // Register writes and counting
    // ---------------------------------------------------------------
    assign wr_rs = sfr_req.wr && sfr_req.addr == dct_pkg::ADDR_RUN_STATUS;
    assign wr_mc = sfr_req.wr && sfr_req.addr == dct_pkg::ADDR_MODE_CONFIG;
    assign wr_cc = sfr_req.wr && sfr_req.addr == dct_pkg::ADDR_CLOCK_CONTROL;
    assign wr_al = sfr_req.wr && sfr_req.addr == dct_pkg::ADDR_A_LOW;
    assign wr_ah = sfr_req.wr && sfr_req.addr == dct_pkg::ADDR_A_HIGH;
    assign wr_bl = sfr_req.wr && sfr_req.addr == dct_pkg::ADDR_B_LOW;
    assign wr_bh = sfr_req.wr && sfr_req.addr == dct_pkg::ADDR_B_HIGH;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_config_reg <= dct_pkg::RST_BYTE; // RULE_24
            clock_control_reg <= dct_pkg::RST_BYTE;
        end else begin
            if (wr_mc) begin
                mode_config_reg <= sfr_req.wdata;
            end
            if (wr_cc) begin
                clock_control_reg <= sfr_req.wdata; // RULE_05
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            run_status_reg <= dct_pkg::RST_BYTE; // RULE_24
        end else begin
            if (wr_rs) begin
                run_status_reg <= sfr_req.wdata; // RULE_10
            end
            if (timer_a_irq_ack && !ovf_a) begin
                run_status_reg[dct_pkg::RS_A_OVF] <= 1'b0; // RULE_21
            end
            if (timer_b_irq_ack) begin
                run_status_reg[dct_pkg::RS_B_OVF] <= 1'b0; // RULE_21
            end
            if (ovf_a) begin
                run_status_reg[dct_pkg::RS_A_OVF] <= 1'b1; // RULE_07
            end
            if (split ? ovf_ah : ovf_b) begin
                run_status_reg[dct_pkg::RS_B_OVF] <= 1'b1; // RULE_16 RULE_17
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            a_low_reg <= dct_pkg::RST_BYTE; // RULE_24
            a_high_reg <= dct_pkg::RST_BYTE;
        end else begin
            if (wr_al) begin
                a_low_reg <= sfr_req.wdata; // RULE_10
            end else if (inc_a) begin
                a_low_reg <= step_a[7:0]; // RULE_15
            end
            if (wr_ah) begin
                a_high_reg <= sfr_req.wdata;
            end else if (inc_ah) begin
                a_high_reg <= a_high_reg + 8'h01; // RULE_16
            end else if (inc_a && !split) begin
                a_high_reg <= step_a[15:8];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            b_low_reg <= dct_pkg::RST_BYTE; // RULE_24
            b_high_reg <= dct_pkg::RST_BYTE;
            b_pulse_reg <= 1'b0;
        end else begin
            b_pulse_reg <= ovf_b; // RULE_19
            if (wr_bl) begin
                b_low_reg <= sfr_req.wdata;
            end else if (inc_b) begin
                b_low_reg <= step_b[7:0]; // RULE_11
            end
            if (wr_bh) begin
                b_high_reg <= sfr_req.wdata;
            end else if (inc_b) begin
                b_high_reg <= step_b[15:8];
            end
        end
    end

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= dct_pkg::RST_BYTE;
        end else if (sfr_req.rd) begin
            if (sfr_req.addr == dct_pkg::ADDR_RUN_STATUS) begin
                rdata_reg <= run_status_reg;
            end else if (sfr_req.addr == dct_pkg::ADDR_MODE_CONFIG) begin
                rdata_reg <= mode_config_reg;
            end else if (sfr_req.addr == dct_pkg::ADDR_A_LOW) begin
                rdata_reg <= a_low_reg;
            end else if (sfr_req.addr == dct_pkg::ADDR_B_LOW) begin
                rdata_reg <= b_low_reg;
            end else if (sfr_req.addr == dct_pkg::ADDR_A_HIGH) begin
                rdata_reg <= a_high_reg;
            end else if (sfr_req.addr == dct_pkg::ADDR_B_HIGH) begin
                rdata_reg <= b_high_reg;
            end else if (sfr_req.addr == dct_pkg::ADDR_CLOCK_CONTROL) begin
                rdata_reg <= clock_control_reg;
            end else begin
                rdata_reg <= dct_pkg::RST_BYTE;
            end
        end
    end

    assign sfr_rdata = rdata_reg;
    assign timer_a_overflow = run_status_reg[dct_pkg::RS_A_OVF];
    assign timer_b_overflow = run_status_reg[dct_pkg::RS_B_OVF];
    assign timer_b_ovf_pulse = b_pulse_reg;
    assign tmr3_high_clk_sel = clock_control_reg[dct_pkg::CC_T3_HIGH]; // RULE_05
    assign tmr3_low_clk_sel = clock_control_reg[dct_pkg::CC_T3_LOW];
    assign tmr2_high_clk_sel = clock_control_reg[dct_pkg::CC_T2_HIGH];
    assign tmr2_low_clk_sel = clock_control_reg[dct_pkg::CC_T2_LOW];

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_div4;
        (pre_tick && prescale_code == dct_pkg::PRE_DIV4) ##1
        (prescale_code == dct_pkg::PRE_DIV4)[*4] |-> pre_tick;
    endproperty
    a_div4: assert property (p_div4) else $error("Divide by 4 tick missing"); // RULE_01
    property p_div12;
        (pre_tick && prescale_code == dct_pkg::PRE_DIV12) |=>
        (!pre_tick || prescale_code != dct_pkg::PRE_DIV12)[*8];
    endproperty
    a_div12: assert property (p_div12) else $error("Divide by 12 tick early"); // RULE_01
    property p_a_ovf;
        ovf_a |=> timer_a_overflow;
    endproperty
    a_a_ovf: assert property (p_a_ovf) else $error("Timer A flag not set"); // RULE_07
    property p_split_flag;
        split && ovf_ah |=> timer_b_overflow;
    endproperty
    a_split_flag: assert property (p_split_flag) else $error("Split high byte flag"); // RULE_16
    property p_split_b_quiet;
        split && !ovf_ah && !timer_b_overflow && !wr_rs |=> !timer_b_overflow;
    endproperty
    a_split_b_quiet: assert property (p_split_b_quiet) else $error("Timer B flag in split"); // RULE_17
    property p_reload;
        mode_a == dct_pkg::MODE_RELOAD && inc_a && a_low_reg == dct_pkg::BYTE_ONES && !wr_al
        |=> a_low_reg == $past(a_high_reg) && timer_a_overflow;
    endproperty
    a_reload: assert property (p_reload) else $error("Reload failed"); // RULE_13
    property p_hold;
        !run_a && !split && !wr_al && !wr_ah |=> $stable(a_low_reg) && $stable(a_high_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("Timer A moved while stopped"); // RULE_09
    property p_edge_pulse;
        ev_a_fall |=> !ev_a_fall;
    endproperty
    a_edge_pulse: assert property (p_edge_pulse) else $error("Edge pulse too long"); // RULE_23
    property p_b_pulse;
        ovf_b |=> timer_b_ovf_pulse ##1 (!timer_b_ovf_pulse || $past(ovf_b));
    endproperty
    a_b_pulse: assert property (p_b_pulse) else $error("Overflow pulse wrong"); // RULE_19
    property p_split_b_run;
        split && mode_b == dct_pkg::MODE_SPLIT && !wr_bl && !wr_bh |=> $stable(b_low_reg);
    endproperty
    a_split_b_run: assert property (p_split_b_run) else $error("Timer B ran in mode 3"); // RULE_18

    c_split_ovf: cover property (split && ovf_ah);
    c_reload: cover property (mode_a == dct_pkg::MODE_RELOAD && ovf_a);
    c_event: cover property (inc_b && ev_b_fall);
endmodule : dct_timer01
`default_nettype wire

// File: dual_counter_timer_prescaler_tb_top.sv
// Testbench for the dual counter/timer block
`timescale 1ns/1ps
`default_nettype none
module dual_counter_timer_prescaler_tb_top;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    dct_pkg::dct_sfr_req_t sfr_req = '0;
    logic ack_a = 1'b0;
    logic ack_b = 1'b0;
    logic irq_a = 1'b0;
    logic pol_a = 1'b0;
    logic irq_b = 1'b0;
    logic pol_b = 1'b1;
    logic [1:0] fire = 2'b00;
    logic [1:0] ev;
    logic osc;
    logic [7:0] rdata;
    logic [7:0] g;
    logic [7:0] g2;
    logic ovf_a;
    logic ovf_b;
    logic pls;
    logic [3:0] sel;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    dct_timer01 u_dct_timer01 (.clk(clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
        .timer_a_irq_ack(ack_a), .timer_b_irq_ack(ack_b), .ext_irq_a_input(irq_a),
        .ext_irq_b_input(irq_b), .ext_irq_a_polarity(pol_a), .ext_irq_b_polarity(pol_b),
        .timer_a_event_pin(ev[0]), .timer_b_event_pin(ev[1]), .ext_osc_clk(osc),
        .sfr_rdata(rdata), .timer_a_overflow(ovf_a), .timer_b_overflow(ovf_b),
        .timer_b_ovf_pulse(pls), .tmr3_high_clk_sel(sel[3]), .tmr3_low_clk_sel(sel[2]),
        .tmr2_high_clk_sel(sel[1]), .tmr2_low_clk_sel(sel[0]));
    dct_pin_model u_dct_pin_model (.clk(clk), .fire(fire), .ev_pin(ev), .osc(osc));
    // ---------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ---------------------------------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 sfr_req = '{1'b1, 1'b0, a, d};
        @(posedge clk);
        #1 sfr_req = '0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        #1 sfr_req = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        #1 sfr_req = '0;
        g = rdata;
    endtask : rd
    task automatic chk(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi,
                       input string m);
        samples_checked++;
        if ((v >= lo && v <= hi) !== 1'b1) begin
            $display("MISMATCH t=%0t %s got %h want %h..%h", $time, m, v, lo, hi);
            n_errors++;
        end
    endtask : chk
    task automatic wait_ovf(input bit b);
        for (int i = 0; i < 600 && (b ? ovf_b : ovf_a) !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
    endtask : wait_ovf
    task automatic pulse_a(input int n, input int p);
        repeat (n) begin
            @(posedge clk);
            #1 fire[p] = 1'b1;
            @(posedge clk);
            #1 fire[p] = 1'b0;
            repeat (6) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        #1;
    endtask : pulse_a
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        for (int a = 8'h88; a <= 8'h8E; a++) begin
            rd(8'(a));
            chk(g, 8'h00, 8'h00, "reset value");
        end
        rd(8'h80);
        chk(g, 8'h00, 8'h00, "unmapped read");
        wr(dct_pkg::ADDR_CLOCK_CONTROL, 8'hF0);
        chk({4'h0, sel}, 8'h0F, 8'h0F, "t2/t3 selects");
        $display("test reset done");
    endtask : t_reset
    task automatic t_prescale();
        logic [7:0] exp [4] = '{8'h10, 8'h30, 8'h04, 8'h06};
        wr(dct_pkg::ADDR_MODE_CONFIG, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr(dct_pkg::ADDR_A_LOW, 8'h00);
            wr(dct_pkg::ADDR_CLOCK_CONTROL, 8'(c));
            wr(dct_pkg::ADDR_RUN_STATUS, 8'h10);
            repeat (191) @(posedge clk);
            wr(dct_pkg::ADDR_RUN_STATUS, 8'h00);
            rd(dct_pkg::ADDR_A_LOW);
            chk(g, exp[c] - 8'h01, exp[c] + 8'h01, "prescaled count");
        end
        $display("test prescale done");
    endtask : t_prescale
    task automatic t_wrap();
        wr(dct_pkg::ADDR_CLOCK_CONTROL, 8'h04);
        for (int m = 0; m < 2; m++) begin
            wr(dct_pkg::ADDR_MODE_CONFIG, 8'(m));
            wr(dct_pkg::ADDR_A_LOW, m == 0 ? 8'h1E : 8'hFE);
            wr(dct_pkg::ADDR_A_HIGH, 8'hFF);
            wr(dct_pkg::ADDR_RUN_STATUS, 8'h10);
            wait_ovf(1'b0);
            chk({7'h00, ovf_a}, 8'h01, 8'h01, "wrap flag");
            wr(dct_pkg::ADDR_RUN_STATUS, 8'h20);
            rd(dct_pkg::ADDR_A_HIGH);
            chk(g, 8'h00, 8'h00, "high after wrap");
            if (m == 0) begin
                wr(dct_pkg::ADDR_RUN_STATUS, 8'h00);
            end else begin
                #0 ack_a = 1'b1;
                @(posedge clk);
                #1 ack_a = 1'b0;
            end
            chk({7'h00, ovf_a}, 8'h00, 8'h00, "flag cleared");
        end
        $display("test wrap done");
    endtask : t_wrap
    task automatic t_reload();
        wr(dct_pkg::ADDR_MODE_CONFIG, 8'h22);
        wr(dct_pkg::ADDR_CLOCK_CONTROL, 8'h0C);
        wr(dct_pkg::ADDR_B_HIGH, 8'hF0);
        wr(dct_pkg::ADDR_B_LOW, 8'hFE);
        wr(dct_pkg::ADDR_A_HIGH, 8'hF8);
        wr(dct_pkg::ADDR_A_LOW, 8'hFE);
        wr(dct_pkg::ADDR_RUN_STATUS, 8'h50);
        wait_ovf(1'b1);
        chk({7'h00, pls}, 8'h01, 8'h01, "overflow pulse");
        repeat (20) @(posedge clk);
        wr(dct_pkg::ADDR_RUN_STATUS, 8'h00);
        rd(dct_pkg::ADDR_B_HIGH);
        chk(g, 8'hF0, 8'hF0, "reload value kept");
        rd(dct_pkg::ADDR_B_LOW);
        chk(g, 8'hF0, 8'hFF, "reloaded low");
        rd(dct_pkg::ADDR_A_LOW);
        chk(g, 8'hF8, 8'hFF, "timer a reloaded low");
        $display("test reload done");
    endtask : t_reload
    task automatic t_event();
        wr(dct_pkg::ADDR_MODE_CONFIG, 8'hD5);
        wr(dct_pkg::ADDR_A_LOW, 8'h00);
        wr(dct_pkg::ADDR_B_LOW, 8'h00);
        wr(dct_pkg::ADDR_RUN_STATUS, 8'h50);
        pulse_a(5, 0);
        pulse_a(2, 1);
        irq_b = 1'b1;
        pulse_a(3, 1);
        rd(dct_pkg::ADDR_A_LOW);
        chk(g, 8'h05, 8'h05, "event count");
        rd(dct_pkg::ADDR_B_LOW);
        chk(g, 8'h03, 8'h03, "timer b gated event count");
        wr(dct_pkg::ADDR_MODE_CONFIG, 8'h0D);
        pol_a = 1'b1;
        pulse_a(3, 0);
        irq_a = 1'b1;
        pulse_a(2, 0);
        pol_a = 1'b0;
        irq_a = 1'b0;
        pulse_a(1, 0);
        rd(dct_pkg::ADDR_A_LOW);
        chk(g, 8'h08, 8'h08, "gated count");
        $display("test event done");
    endtask : t_event
    task automatic t_split();
        wr(dct_pkg::ADDR_RUN_STATUS, 8'h00);
        wr(dct_pkg::ADDR_MODE_CONFIG, 8'h43);
        wr(dct_pkg::ADDR_CLOCK_CONTROL, 8'h0C);
        wr(dct_pkg::ADDR_A_HIGH, 8'hFE);
        wr(dct_pkg::ADDR_RUN_STATUS, 8'h40);
        wait_ovf(1'b1);
        chk({7'h00, ovf_b}, 8'h01, 8'h01, "split high sets b flag");
        rd(dct_pkg::ADDR_B_LOW);
        g2 = g;
        rd(dct_pkg::ADDR_B_LOW);
        chk({7'h00, g !== g2}, 8'h01, 8'h01, "b runs in mode 0");
        wr(dct_pkg::ADDR_MODE_CONFIG, 8'h33);
        rd(dct_pkg::ADDR_B_LOW);
        g2 = g;
        rd(dct_pkg::ADDR_B_LOW);
        chk(g, g2, g2, "b stops in mode 3");
        $display("test split done");
    endtask : t_split
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5) @(posedge clk);
        #1 sys_rst = 1'b0;
        t_reset();
        t_prescale();
        t_wrap();
        t_reload();
        t_event();
        t_split();
        give_verdict();
    end
endmodule : dual_counter_timer_prescaler_tb_top
`default_nettype wire
